// >>> logic/pspc_ctrl.sv
// pspc_ctrl.sv: processing state and privilege control of the core
// assumes core strobes on clk; irq, breakpoint and bus error are pins
//
// What this block does
// RULE1: unless halted, exactly one of three states
// RULE2: stop instructions give stopped, no bus cycles
// RULE3: exception covers stacking, vector fetch, refill
// RULE4: exception ends when handler starts executing
// RULE5: interrupts, traps, breakpoints, bus errors raise exceptions
// RULE6: bus or address error during exception halts
// RULE7: only an outside reset leaves the halt
// RULE8: privilege flag picks level and stack pointer
// RULE9: supervisor code gets supervisor spaces, user user
// RULE10: exception processing always runs as supervisor
// RULE11: user level cannot run privileged instructions
// RULE12: user level stack references use user pointer
// RULE13: entry pushes state word, then sets privilege
// RULE14: state writes and returns flush the pipeline; stop instructions load the word without a flush
// RULE15: normal return restores state word and counter
// RULE16: bus fault return restores full internal state
// RULE17: three-bit space codes on every bus cycle
// RULE18: halted issues no bus cycles, ignores requests
// RULE19: user privileged attempt raises an exception
`timescale 1ns/1ps
`include "pspc_regs.svh"
module pspc_ctrl #(
   parameter int STACK_WORDS = `PSPC_STACK_WORDS,
   parameter int VECTOR_WORDS = `PSPC_VECTOR_WORDS,
   parameter int REFILL_WORDS = `PSPC_REFILL_WORDS
)(
   input logic clk,
   input logic arst_n,
   input logic instr_valid,
   input logic [3:0] instr_kind,
   input logic [15:0] instr_operand,
   input logic core_exc_req,
   input logic addr_error,
   input logic bkgd_enter,
   input logic bkgd_exit,
   input logic irq_pin,
   input logic bkpt_pin,
   input logic bus_error_pin,
   input logic ret_frame_fault,
   input logic [15:0] ret_state_word,
   input logic bus_req,
   input logic bus_program,
   input logic bus_cpu_space,
   input logic bus_done,
   output logic [2:0] proc_state,
   output logic stopped,
   output logic halted,
   output logic supervisor,
   output logic user_stack_pointer_sel,
   output logic [15:0] processor_state_word,
   output logic [15:0] saved_state_word,
   output logic stack_push,
   output logic vector_fetch,
   output logic pipe_flush,
   output logic restore_pc_state,
   output logic restore_full,
   output logic priv_violation,
   output logic ext_reset_req,
   output logic bus_start,
   output logic [2:0] bus_space_code
);

   localparam int CW = `PSPC_CNT_W;
   localparam logic [CW-1:0] STACK_LAST = CW'(STACK_WORDS - 1);
   localparam logic [CW-1:0] VECTOR_LAST = CW'(VECTOR_WORDS - 1);
   localparam logic [CW-1:0] REFILL_LAST = CW'(REFILL_WORDS - 1);

   pspc_pkg::pspc_state_t state;
   pspc_ctrl_if cif ();
   logic [2:0] pin_in;
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [2:0] sync_c;
   logic irq_evt;
   logic bkpt_evt;
   logic bus_err_evt;
   logic in_exc;
   logic run_normal;
   logic exc_event;
   logic fatal;
   logic instr_ok;
   logic outstanding;
   logic issue_exc;
   logic issue_normal;
   logic word_done;
   logic phase_last;
   logic [CW-1:0] word_cnt;
   logic [15:0] next_state_word;
   pspc_pkg::pspc_instr_t kind;

   // ****************************************************************
   // elaboration checks
   // ****************************************************************

   // word counts must fit the counter and be at least one
   generate
      if (STACK_WORDS < 1 || STACK_WORDS > 255 || VECTOR_WORDS < 1 || VECTOR_WORDS > 255 ||
          REFILL_WORDS < 1 || REFILL_WORDS > 255)
      begin : g_bad_counts
         $error("pspc_ctrl: word counts must lie in 1 to 255");
      end
   endgenerate

   // ****************************************************************
   // pin synchronisers and edge detection
   // ****************************************************************

   assign pin_in = {bus_error_pin, bkpt_pin, irq_pin};

   // two flops per pin, a third only for the edge detector
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_sync
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               sync_a[gi] <= 1'h0;
               sync_b[gi] <= 1'h0;
               sync_c[gi] <= 1'h0;
            end
            else
            begin
               sync_a[gi] <= pin_in[gi];
               sync_b[gi] <= sync_a[gi];
               sync_c[gi] <= sync_b[gi];
            end
         end
      end
   endgenerate

   // rising edges become one-cycle events
   assign irq_evt = sync_b[0] & ~sync_c[0];
   assign bkpt_evt = sync_b[1] & ~sync_c[1];
   assign bus_err_evt = sync_b[2] & ~sync_c[2];

   // ****************************************************************
   // helper instances
   // ****************************************************************

   assign kind = pspc_pkg::pspc_instr_t'(instr_kind);
   assign in_exc = (state == pspc_pkg::st_exc_stack) || (state == pspc_pkg::st_exc_vector) ||
                   (state == pspc_pkg::st_exc_refill);

   // privilege seen by the helpers; the flag is already set in exception
   assign cif.supervisor = processor_state_word[`PSPC_S_BIT]; // [RULE8] [RULE10]
   assign cif.prog = in_exc ? (state == pspc_pkg::st_exc_refill) : bus_program;
   assign cif.cpu_space = ~in_exc & bus_cpu_space;
   assign cif.instr_valid = instr_valid & run_normal;
   assign cif.instr_kind = kind;

   pspc_space_coder u_coder (
      .cif(cif.coder)
   );

   pspc_priv_guard u_guard (
      .cif(cif.guard)
   );

   // ****************************************************************
   // event decode
   // ****************************************************************

   // normal processing that is not stopped runs instructions
   assign run_normal = (state == pspc_pkg::st_normal) & ~stopped;

   // any cause of exception entry while in normal processing
   assign exc_event = (state == pspc_pkg::st_normal) &
                      (core_exc_req | irq_evt | bkpt_evt | bus_err_evt | addr_error |
                       cif.priv_fault); // [RULE5] [RULE19]

   // a second fault before the handler starts is fatal
   assign fatal = in_exc & (bus_err_evt | addr_error); // [RULE6]

   // instruction takes effect only when no exception preempts it
   assign instr_ok = run_normal & instr_valid & ~exc_event;

   // ****************************************************************
   // processing state machine
   // ****************************************************************

   assign word_done = outstanding & bus_done;

   // last word of the current exception phase
   always_comb
   begin
      case (state)
         pspc_pkg::st_exc_stack:
            phase_last = (word_cnt == STACK_LAST);
         pspc_pkg::st_exc_vector:
            phase_last = (word_cnt == VECTOR_LAST);
         pspc_pkg::st_exc_refill:
            phase_last = (word_cnt == REFILL_LAST);
         default:
            phase_last = 1'h0;
      endcase
   end

   // one state at a time; halted held until the external reset
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         state <= pspc_pkg::st_normal; // [RULE7]
      else
      begin
         case (state)
            pspc_pkg::st_normal:
            begin
               if (exc_event)
                  state <= pspc_pkg::st_exc_stack; // [RULE5]
               else if (bkgd_enter)
                  state <= pspc_pkg::st_background; // [RULE1]
            end
            pspc_pkg::st_background:
            begin
               if (bkgd_exit)
                  state <= pspc_pkg::st_normal; // [RULE1]
            end
            pspc_pkg::st_exc_stack:
            begin
               if (fatal)
                  state <= pspc_pkg::st_halted; // [RULE6]
               else if (word_done & phase_last)
                  state <= pspc_pkg::st_exc_vector; // [RULE3]
            end
            pspc_pkg::st_exc_vector:
            begin
               if (fatal)
                  state <= pspc_pkg::st_halted; // [RULE6]
               else if (word_done & phase_last)
                  state <= pspc_pkg::st_exc_refill; // [RULE3]
            end
            pspc_pkg::st_exc_refill:
            begin
               if (fatal)
                  state <= pspc_pkg::st_halted; // [RULE6]
               else if (word_done & phase_last)
                  state <= pspc_pkg::st_normal; // [RULE4]
            end
            pspc_pkg::st_halted:
               state <= pspc_pkg::st_halted; // [RULE7] [RULE18]
            default:
               state <= pspc_pkg::st_normal;
         endcase
      end
   end

   assign proc_state = state;

   // halt flag set with the halted state
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         halted <= 1'h0;
      else if (fatal)
         halted <= 1'h1; // [RULE6] [RULE7]
   end

   // ****************************************************************
   // exception word counter
   // ****************************************************************

   // completed words of the current phase
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         word_cnt <= '0;
      else if (!in_exc || fatal)
         word_cnt <= '0;
      else if (word_done)
         word_cnt <= phase_last ? '0 : word_cnt + CW'(1); // [RULE3]
   end

   // ****************************************************************
   // stopped sub-state
   // ****************************************************************

   // stop parks normal processing, no bus cycles
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         stopped <= 1'h0;
      else if (state != pspc_pkg::st_normal || exc_event || bkgd_enter)
         stopped <= 1'h0;
      else if (instr_ok && (kind == pspc_pkg::ik_stop || kind == pspc_pkg::ik_low_power_halt_instruction))
         stopped <= 1'h1; // [RULE2]
   end

   // ****************************************************************
   // processor state word
   // ****************************************************************

   // entry sets privilege, instructions rewrite
   always_comb
   begin
      next_state_word = processor_state_word;
      if (exc_event)
         next_state_word[`PSPC_S_BIT] = 1'h1; // [RULE13] [RULE10]
      else if (instr_ok)
      begin
         case (kind)
            pspc_pkg::ik_stop,
            pspc_pkg::ik_low_power_halt_instruction,
            pspc_pkg::ik_move_to_state:
               next_state_word = instr_operand;
            pspc_pkg::ik_and_immediate_to_state:
               next_state_word = processor_state_word & instr_operand;
            pspc_pkg::ik_xor_immediate_to_state:
               next_state_word = processor_state_word ^ instr_operand;
            pspc_pkg::ik_or_immediate_to_state:
               next_state_word = processor_state_word | instr_operand;
            pspc_pkg::ik_exception_return_instruction:
               next_state_word = ret_state_word; // [RULE15] [RULE16]
            default:
               next_state_word = processor_state_word;
         endcase
      end
   end

   // word, privilege and stack choice together
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         processor_state_word <= `PSPC_STATE_RESET;
         supervisor <= 1'h1;
         user_stack_pointer_sel <= 1'h0;
      end
      else
      begin
         processor_state_word <= next_state_word;
         supervisor <= next_state_word[`PSPC_S_BIT]; // [RULE8]
         user_stack_pointer_sel <= ~next_state_word[`PSPC_S_BIT]; // [RULE8] [RULE12] [RULE10]
      end
   end

   // whole word saved before privilege is forced
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         saved_state_word <= `PSPC_STATE_RESET;
      else if (exc_event)
         saved_state_word <= processor_state_word; // [RULE13]
   end

   // ****************************************************************
   // instruction side effects
   // ****************************************************************

   // one-cycle strobes for flush, restore, reset and violation
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pipe_flush <= 1'h0;
         restore_pc_state <= 1'h0;
         restore_full <= 1'h0;
         ext_reset_req <= 1'h0;
         priv_violation <= 1'h0;
      end
      else
      begin
         pipe_flush <= instr_ok && (kind == pspc_pkg::ik_move_to_state ||
                       kind == pspc_pkg::ik_and_immediate_to_state ||
                       kind == pspc_pkg::ik_xor_immediate_to_state ||
                       kind == pspc_pkg::ik_or_immediate_to_state ||
                       kind == pspc_pkg::ik_exception_return_instruction); // [RULE14]
         restore_pc_state <= instr_ok && kind == pspc_pkg::ik_exception_return_instruction &&
                             !ret_frame_fault; // [RULE15]
         restore_full <= instr_ok && kind == pspc_pkg::ik_exception_return_instruction &&
                         ret_frame_fault; // [RULE16]
         ext_reset_req <= instr_ok && kind == pspc_pkg::ik_reset;
         priv_violation <= cif.priv_fault; // [RULE19]
      end
   end

   // ****************************************************************
   // bus cycle issue
   // ****************************************************************

   // exception words go one at a time; the core only runs unstopped
   assign issue_exc = in_exc & ~outstanding & ~bus_start & ~fatal; // [RULE3]
   assign issue_normal = ((run_normal & ~exc_event) | (state == pspc_pkg::st_background)) &
                         bus_req; // [RULE2] [RULE18]

   // one outstanding exception word at a time
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         outstanding <= 1'h0;
      else if (!in_exc || fatal)
         outstanding <= 1'h0;
      else if (bus_start)
         outstanding <= 1'h1;
      else if (bus_done)
         outstanding <= 1'h0;
   end

   // start strobe, its space code and the kind of exception word
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bus_start <= 1'h0;
         bus_space_code <= `PSPC_FC_SUPER_PROG;
         stack_push <= 1'h0;
         vector_fetch <= 1'h0;
      end
      else
      begin
         bus_start <= issue_exc | issue_normal; // [RULE18]
         if (issue_exc | issue_normal)
            bus_space_code <= cif.space_code; // [RULE9] [RULE10] [RULE17]
         stack_push <= issue_exc && state == pspc_pkg::st_exc_stack; // [RULE13]
         vector_fetch <= issue_exc && state == pspc_pkg::st_exc_vector; // [RULE3]
      end
   end

endmodule

// >>> inc/pspc_regs.svh
// pspc_regs.svh: constants of the processing state and privilege control
// assumes it is included by its bare name from inc/
`ifndef PSPC_REGS_SVH
`define PSPC_REGS_SVH

// ****************************************************************
// state word layout and reset
// ****************************************************************
`define PSPC_STATE_W 16
`define PSPC_S_BIT 13
`define PSPC_STATE_RESET 16'h2000

// ****************************************************************
// bus space codes
// ****************************************************************
`define PSPC_FC_USER_DATA 3'h1
`define PSPC_FC_USER_PROG 3'h2
`define PSPC_FC_SUPER_DATA 3'h5
`define PSPC_FC_SUPER_PROG 3'h6
`define PSPC_FC_CPU 3'h7

// ****************************************************************
// exception word counts
// ****************************************************************
`define PSPC_CNT_W 8
`define PSPC_STACK_WORDS 4
`define PSPC_VECTOR_WORDS 2
`define PSPC_REFILL_WORDS 2

`endif

// >>> inc/pspc_pkg.sv
// pspc_pkg.sv: types of the processing state and privilege control
// assumes nothing of its surroundings
package pspc_pkg;

   // processing states, gray along normal to exception and back
   typedef enum logic [2:0] {
      st_normal = 3'h0,
      st_exc_stack = 3'h1,
      st_exc_vector = 3'h3,
      st_exc_refill = 3'h2,
      st_background = 3'h4,
      st_halted = 3'h6
   } pspc_state_t;

   // instruction classes the core reports
   typedef enum logic [3:0] {
      ik_plain = 4'h0,
      ik_stop = 4'h1,
      ik_low_power_halt_instruction = 4'h2,
      ik_reset = 4'h3,
      ik_move_to_state = 4'h4,
      ik_and_immediate_to_state = 4'h5,
      ik_xor_immediate_to_state = 4'h6,
      ik_or_immediate_to_state = 4'h7,
      ik_exception_return_instruction = 4'h8
   } pspc_instr_t;

endpackage

// >>> inc/pspc_ctrl_if.sv
// pspc_ctrl_if.sv: signals between the control and its helpers
// assumes all parties share one clock
`timescale 1ns/1ps
interface pspc_ctrl_if;
   logic supervisor;
   logic prog;
   logic cpu_space;
   logic [2:0] space_code;
   logic instr_valid;
   pspc_pkg::pspc_instr_t instr_kind;
   logic priv_fault;

   modport ctrl (output supervisor, output prog, output cpu_space, output instr_valid,
                 output instr_kind, input space_code, input priv_fault);
   modport coder (input supervisor, input prog, input cpu_space, output space_code);
   modport guard (input instr_valid, input instr_kind, input supervisor, output priv_fault);
endinterface

// >>> logic/pspc_space_coder.sv
// pspc_space_coder.sv: bus space code from privilege and access kind
// assumes the control registers the code with each bus start
`timescale 1ns/1ps
`include "pspc_regs.svh"
module pspc_space_coder (
   pspc_ctrl_if.coder cif
);

   // ****************************************************************
   // space code selection
   // ****************************************************************

   // processor space wins, then privilege, then program or data
   always_comb
   begin
      if (cif.cpu_space)
         cif.space_code = `PSPC_FC_CPU; // [RULE17]
      else if (cif.supervisor)
         cif.space_code = cif.prog ? `PSPC_FC_SUPER_PROG : `PSPC_FC_SUPER_DATA; // [RULE9] [RULE17]
      else
         cif.space_code = cif.prog ? `PSPC_FC_USER_PROG : `PSPC_FC_USER_DATA; // [RULE9] [RULE17]
   end

endmodule

// >>> logic/pspc_priv_guard.sv
// pspc_priv_guard.sv: flags privileged instructions met at user level
// assumes instr_valid marks one decoded instruction per pulse
`timescale 1ns/1ps
module pspc_priv_guard (
   pspc_ctrl_if.guard cif
);

   logic privileged;

   // ****************************************************************
   // privileged instruction check
   // ****************************************************************

   // stops, reset and anything that can alter the privilege flag
   always_comb
   begin
      case (cif.instr_kind)
         pspc_pkg::ik_stop,
         pspc_pkg::ik_low_power_halt_instruction,
         pspc_pkg::ik_reset,
         pspc_pkg::ik_move_to_state,
         pspc_pkg::ik_and_immediate_to_state,
         pspc_pkg::ik_xor_immediate_to_state,
         pspc_pkg::ik_or_immediate_to_state,
         pspc_pkg::ik_exception_return_instruction:
            privileged = 1'h1; // [RULE11]
         default:
            privileged = 1'h0;
      endcase
   end

   // a user attempt becomes a fault, never a silent no-op
   assign cif.priv_fault = cif.instr_valid & privileged & ~cif.supervisor; // [RULE11] [RULE19]

endmodule

// >>> dv/pspc_bus_model.sv
// pspc_bus_model.sv: external bus that ends each started cycle unless a new start arrives before its done
// assumes bus_start is a one-cycle pulse on clk
`timescale 1ns/1ps
module pspc_bus_model (
   input logic clk,
   input logic arst_n,
   input logic bus_start,
   input logic slow,
   output logic bus_done
);
   logic [2:0] wait_cnt;

   // one done two or five cycles after the latest start pulse; a newer start drops the done of the older one
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wait_cnt <= 3'h0;
         bus_done <= 1'b0;
      end
      else
      begin
         bus_done <= (wait_cnt == 3'h1) && !bus_start;
         if (bus_start)
            wait_cnt <= slow ? 3'h4 : 3'h1;
         else if (wait_cnt != 3'h0)
            wait_cnt <= wait_cnt - 3'h1;
      end
   end
endmodule

// >>> dv/pspc_ctrl_sva.sv
// pspc_ctrl_sva.sv: timing checks on the ports of pspc_ctrl
// assumes one clock domain with the asynchronous reset arst_n
`timescale 1ns/1ps
module pspc_ctrl_sva (
   input logic clk,
   input logic arst_n,
   input logic instr_valid,
   input logic [3:0] instr_kind,
   input logic [15:0] instr_operand,
   input logic core_exc_req,
   input logic addr_error,
   input logic bus_program,
   input logic bus_cpu_space,
   input logic [2:0] proc_state,
   input logic stopped,
   input logic halted,
   input logic supervisor,
   input logic user_stack_pointer_sel,
   input logic [15:0] processor_state_word,
   input logic [15:0] saved_state_word,
   input logic pipe_flush,
   input logic priv_violation,
   input logic bus_start,
   input logic [2:0] bus_space_code
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // entry, and a taken state word write
   sequence s_entry;
      proc_state == 3'h0 ##1 proc_state == 3'h1;
   endsequence
   sequence s_move;
      instr_valid && instr_kind == 4'h4 && proc_state == 3'h0 && !stopped && supervisor && !core_exc_req && !addr_error;
   endsequence

   // state and space checks
   a_state_legal: assert property (!(proc_state inside {3'h5, 3'h7}))
      else $error("bad state");
   a_halt_match: assert property (halted == (proc_state == 3'h6))
      else $error("halt flag");
   a_stop_quiet: assert property (stopped |-> !bus_start)
      else $error("bus while stopped");
   a_exc_super: assert property (proc_state inside {[3'h1:3'h3]} |-> supervisor)
      else $error("exc not supervisor");
   a_exc_spaces: assert property (bus_start && proc_state inside {3'h1, 3'h3} |-> bus_space_code == 3'h5)
      else $error("exc data space");
   a_refill_space: assert property (bus_start && proc_state == 3'h2 |-> bus_space_code == 3'h6)
      else $error("refill space");
   a_fault_halt: assert property (proc_state inside {[3'h1:3'h3]} && addr_error |=> halted)
      else $error("no halt");
   a_halt_sticky: assert property (halted |=> halted && !bus_start)
      else $error("halt left");
   a_stack_sel: assert property (user_stack_pointer_sel != supervisor && supervisor == processor_state_word[13])
      else $error("stack select");
   a_norm_space: assert property (bus_start && $past(proc_state) == 3'h0 && !$past(bus_cpu_space)
      |-> bus_space_code == {$past(supervisor), $past(bus_program), !$past(bus_program)})
      else $error("normal space");
   a_priv_entry: assert property (priv_violation |-> proc_state == 3'h1 && supervisor)
      else $error("fault no entry");
   a_entry_save: assert property (s_entry |-> supervisor && !stopped && saved_state_word == $past(processor_state_word))
      else $error("entry save");
   a_move_flush: assert property (s_move |=> pipe_flush && processor_state_word == $past(instr_operand))
      else $error("no flush");
endmodule

bind pspc_ctrl pspc_ctrl_sva i_sva (.*);

// >>> dv/processing_state_privilege_ctrl_test.sv
// processing_state_privilege_ctrl_test.sv: self-checking bench of pspc_ctrl
// assumes the bus model answers every started bus cycle
`timescale 1ns/1ps
module processing_state_privilege_ctrl_test;
   `define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; $display("[ERR] %0t %h %h", $time, a, e); end end
   typedef struct {pspc_pkg::pspc_instr_t k; logic [15:0] w, rw; logic ff; logic [15:0] ew; logic [4:0] ef;} pspc_row_t;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic instr_valid, core_exc_req, addr_error, bkgd_enter, bkgd_exit, irq_pin, bkpt_pin, bus_error_pin;
   logic ret_frame_fault, bus_req, bus_program, bus_cpu_space, bus_done, slow, stopped, halted, supervisor;
   logic [3:0] instr_kind;
   logic [15:0] instr_operand, ret_state_word, processor_state_word, saved_state_word;
   logic [2:0] proc_state, bus_space_code;
   logic user_stack_pointer_sel, stack_push, vector_fetch, pipe_flush, restore_pc_state, restore_full;
   logic priv_violation, ext_reset_req, bus_start;
   int mismatches = 0;
   int total_checks = 0;
   // flags: stopped, flush, fault, restore, full
   pspc_row_t rows [6] = '{
      '{pspc_pkg::ik_move_to_state, 16'h2700, 16'h0000, 1'b0, 16'h2700, 5'h08},
      '{pspc_pkg::ik_or_immediate_to_state, 16'h0001, 16'h0000, 1'b0, 16'h2701, 5'h08},
      '{pspc_pkg::ik_and_immediate_to_state, 16'hFFFE, 16'h0000, 1'b0, 16'h2700, 5'h08},
      '{pspc_pkg::ik_xor_immediate_to_state, 16'h0100, 16'h0000, 1'b0, 16'h2600, 5'h08},
      '{pspc_pkg::ik_exception_return_instruction, 16'h0000, 16'h2000, 1'b1, 16'h2000, 5'h09},
      '{pspc_pkg::ik_exception_return_instruction, 16'h0000, 16'h0004, 1'b0, 16'h0004, 5'h0A}};

   pspc_ctrl i_dut (.*);
   pspc_bus_model i_bus (.*);

   // 10 MHz clock
   always #50 clk = ~clk;

   task automatic end_of_test;
      if (mismatches == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // bounded wait for a state or bus done
   task automatic wait_for(input logic [2:0] st, input logic done);
      int n;
      for (n = 0; n < 300; n++)
      begin
         @(negedge clk);
         if (done ? bus_done === 1'b1 : proc_state === st)
            break;
      end
      if (n == 300)
      begin
         mismatches++;
         end_of_test();
      end
   endtask

   // reset, then check reset values
   task automatic do_reset;
      arst_n = 1'b0;
      repeat (10) @(negedge clk);
      `CHK({proc_state, stopped, halted, supervisor, user_stack_pointer_sel, bus_space_code}, 10'h016)
      `CHK({processor_state_word, saved_state_word}, 32'h20002000)
      arst_n = 1'b1;
      @(negedge clk);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask

   task automatic op(input pspc_pkg::pspc_instr_t k, input logic [15:0] w);
      instr_kind = k;
      instr_operand = w;
      pulse(instr_valid);
   endtask

   // one bus cycle and its space code
   task automatic bus(input logic p, input logic c, input logic [2:0] e);
      bus_program = p;
      bus_cpu_space = c;
      pulse(bus_req);
      `CHK({bus_start, bus_space_code}, {1'b1, e})
      wait_for(3'h0, 1'b1);
   endtask

   initial
   begin
      {instr_valid, core_exc_req, addr_error, bkgd_enter, bkgd_exit, irq_pin, bkpt_pin, bus_error_pin} = '0;
      {ret_frame_fault, bus_req, bus_program, bus_cpu_space, slow, instr_kind, instr_operand, ret_state_word} = '0;
      do_reset();
      op(pspc_pkg::ik_reset, 16'h0000);
      `CHK(ext_reset_req, 1'b1)
      foreach (rows[i])
      begin
         ret_state_word = rows[i].rw;
         ret_frame_fault = rows[i].ff;
         op(rows[i].k, rows[i].w);
         `CHK(processor_state_word, rows[i].ew)
         `CHK({stopped, pipe_flush, priv_violation, restore_pc_state, restore_full}, rows[i].ef)
         `CHK({supervisor, user_stack_pointer_sel}, {rows[i].ew[13], ~rows[i].ew[13]})
      end
      // user spaces, then user stop faults
      bus(1'b0, 1'b0, 3'h1);
      bus(1'b1, 1'b0, 3'h2);
      bus(1'b0, 1'b1, 3'h7);
      op(pspc_pkg::ik_stop, 16'h2700);
      `CHK({proc_state, priv_violation, supervisor, stopped}, 6'h0E)
      `CHK(saved_state_word, 16'h0004)
      wait_for(3'h0, 1'b0);
      slow = 1'b1;
      bus(1'b0, 1'b0, 3'h5);
      bus(1'b1, 1'b0, 3'h6);
      // stop holds off the bus till irq
      op(pspc_pkg::ik_stop, 16'h2700);
      bus_req = 1'b1;
      repeat (4) @(negedge clk);
      `CHK({stopped, bus_start, processor_state_word}, 18'h22700)
      irq_pin = 1'b1;
      wait_for(3'h1, 1'b0);
      bus_req = 1'b0;
      `CHK(stopped, 1'b0)
      wait_for(3'h0, 1'b0);
      irq_pin = 1'b0;
      // background ignores exceptions
      pulse(bkgd_enter);
      pulse(core_exc_req);
      `CHK(proc_state, 3'h4)
      pulse(bkgd_exit);
      `CHK(proc_state, 3'h0)
      // fault in exception halts
      for (int i = 0; i < 2; i++)
      begin
         if (i == 0)
            pulse(core_exc_req);
         else
            bkpt_pin = 1'b1;
         wait_for(3'h1, 1'b0);
         if (i == 0)
            pulse(addr_error);
         else
            bus_error_pin = 1'b1;
         wait_for(3'h6, 1'b0);
         {irq_pin, bus_req} = 2'b11;
         repeat (8) @(negedge clk);
         `CHK({halted, proc_state, bus_start}, 5'h1C)
         {irq_pin, bus_req, bkpt_pin, bus_error_pin} = 4'h0;
         do_reset();
      end
      end_of_test();
   end
endmodule
